// >>> hw/dprt_pkg.sv
package dprt_pkg;

    // ------------------------------------------------------------
    // operating arrangements
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DPRT_MODE_INDEP = 2'b00,
        DPRT_MODE_P8P8  = 2'b01,
        DPRT_MODE_W16   = 2'b10,
        DPRT_MODE_RSVD  = 2'b11
    } dprt_mode_t;

    // ------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------
    localparam int          CH_W       = 8;
    localparam logic [7:0]  CNT_RST    = 8'h00;
    localparam logic        PIN_RST    = 1'b0;

endpackage

// >>> hw/dprt_chan.sv
`timescale 1ns/10ps
// one 8-bit down counter with low/high reload alternation
module dprt_chan #(
    parameter int W = 8
) (
    input  wire logic         core_clk,
    input  wire logic         rst,
    input  wire logic         ce,
    input  wire logic         run,
    input  wire logic         tick,
    input  wire logic [W-1:0] rld_low,
    input  wire logic [W-1:0] rld_high,
    output logic              uflow,
    output logic              phase
);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         ph;
    } dprt_ch_st_t;

    dprt_ch_st_t st_reg;
    dprt_ch_st_t st_next;

    assign uflow = run && tick && (st_reg.cnt == '0);
    assign phase = st_reg.ph;

    always_comb begin
        st_next = st_reg;
        if (!run) begin
            st_next.cnt = rld_low;
            st_next.ph  = 1'b0;
        end else if (tick) begin
            if (st_reg.cnt == '0) begin
                // reload alternates low/high value
                st_next.ph  = ~st_reg.ph;
                st_next.cnt = st_reg.ph ? rld_low : rld_high;
            end else begin
                st_next.cnt = st_reg.cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_reg <= '0;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

endmodule

// >>> hw/dprt_top.sv
`timescale 1ns/10ps
module dprt_top #(
    parameter int W = dprt_pkg::CH_W
) (
    input  wire logic         core_clk,
    input  wire logic         rst,
    input  wire logic         ce,
    input  wire logic         run_zero,
    input  wire logic         run_one,
    input  wire logic [1:0]   mode,
    input  wire logic [W-1:0] zero_rld_low,
    input  wire logic [W-1:0] zero_rld_high,
    input  wire logic [W-1:0] one_rld_low,
    input  wire logic [W-1:0] one_rld_high,
    output logic              pulse_channel_zero,
    output logic              pulse_channel_one
);

    // ------------------------------------------------------------
    // mode decoding
    // ------------------------------------------------------------
    function automatic logic is_w16(input logic [1:0] m);
        return m == dprt_pkg::DPRT_MODE_W16;
    endfunction

    function automatic logic is_p8p8(input logic [1:0] m);
        return m == dprt_pkg::DPRT_MODE_P8P8;
    endfunction

    function automatic logic is_indep(input logic [1:0] m);
        return m == dprt_pkg::DPRT_MODE_INDEP;
    endfunction

    // ------------------------------------------------------------
    // channel wiring
    // ------------------------------------------------------------
    logic uf0;
    logic uf1;
    logic ph0;
    logic ph1;
    logic run1;
    logic tick1;
    logic casc;
    logic m_w16;
    logic m_p8p8;
    logic m_indep;

    // one decode per arrangement, m_w16 and m_p8p8 shared by wiring and checks, m_indep used by checks only; the pin logic decodes mode itself
    assign m_w16   = is_w16(mode);
    assign m_p8p8  = is_p8p8(mode);
    assign m_indep = is_indep(mode);

    // 16-bit and 8+8 both clock channel 1 from channel 0 underflow
    assign casc  = m_w16 || m_p8p8;
    assign tick1 = casc ? uf0 : 1'b1;
    assign run1  = casc ? (run_zero && run_one) : run_one;

    // in 16-bit mode channel 0 runs a flat reload so both halves form one count
    logic [W-1:0] z_high;
    assign z_high = m_w16 ? zero_rld_low : zero_rld_high;

    dprt_chan #(.W(W)) u_ch0 (
        .core_clk (core_clk),
        .rst      (rst),
        .ce       (ce),
        .run      (run_zero),
        .tick     (1'b1),
        .rld_low  (zero_rld_low),
        .rld_high (z_high),
        .uflow    (uf0),
        .phase    (ph0)
    );

    dprt_chan #(.W(W)) u_ch1 (
        .core_clk (core_clk),
        .rst      (rst),
        .ce       (ce),
        .run      (run1),
        .tick     (tick1),
        .rld_low  (one_rld_low),
        .rld_high (one_rld_high),
        .uflow    (uf1),
        .phase    (ph1)
    );

    // ------------------------------------------------------------
    // output pins
    // ------------------------------------------------------------
    typedef struct packed {
        logic p0;
        logic p1;
        logic tog0;
    } dprt_st_t;

    dprt_st_t st_reg;
    dprt_st_t st_next;

    always_comb begin
        st_next = st_reg;
        if (uf0) begin
            st_next.tog0 = ~st_reg.tog0;
        end
        if (!run_zero) begin
            st_next.tog0 = dprt_pkg::PIN_RST;
        end
        unique case (mode)
            dprt_pkg::DPRT_MODE_INDEP: begin
                st_next.p0 = run_zero & ph0;
                st_next.p1 = run_one & ph1;
            end
            dprt_pkg::DPRT_MODE_P8P8: begin
                st_next.p0 = st_next.tog0;
                st_next.p1 = run1 & ph1;
            end
            dprt_pkg::DPRT_MODE_W16: begin
                st_next.p0 = run1 & ph1;
                st_next.p1 = run1 & ph1;
            end
            default: begin
                st_next.p0 = dprt_pkg::PIN_RST;
                st_next.p1 = dprt_pkg::PIN_RST;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_reg <= '0;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    assign pulse_channel_zero = st_reg.p0;
    assign pulse_channel_one  = st_reg.p1;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // upper underflow, then one more running cycle while the new phase reaches the pins
    sequence upper_step_s;
        (m_w16 && ce && uf1 && run1) ##1 (ce && run1);
    endsequence

    // lower underflow taken on an enabled edge
    sequence lower_uf_s;
        ce && uf0;
    endsequence

    // no lower underflow, so a cascaded upper channel must not step
    sequence no_lower_step_s;
        casc && ce && run1 && !uf0;
    endsequence

    w16_same_a: assert property (@(posedge core_clk) disable iff (rst)
        (mode == dprt_pkg::DPRT_MODE_W16) && $stable(mode) |=>
            pulse_channel_zero == pulse_channel_one)
        else $error("pins differ in 16-bit mode");

    w16_flip_a: assert property (@(posedge core_clk) disable iff (rst)
        upper_step_s |=>
            pulse_channel_zero != $past(pulse_channel_zero))
        else $error("16-bit pins did not invert on upper underflow");

    p8_tog_a: assert property (@(posedge core_clk) disable iff (rst)
        (mode == dprt_pkg::DPRT_MODE_P8P8) && ce && uf0 && run_zero |=>
            pulse_channel_zero != $past(pulse_channel_zero))
        else $error("prescaler pin did not toggle");

    p8_clk_a: assert property (@(posedge core_clk) disable iff (rst)
        casc && uf1 |-> uf0)
        else $error("channel 1 stepped without channel 0 underflow");

    ind_pin_a: assert property (@(posedge core_clk) disable iff (rst)
        (mode == dprt_pkg::DPRT_MODE_INDEP) && ce |=> pulse_channel_one == $past(run_one & ph1))
        else $error("independent pin 1 wrong");

    ind_pin0_a: assert property (@(posedge core_clk) disable iff (rst)
        (mode == dprt_pkg::DPRT_MODE_INDEP) && ce |=> pulse_channel_zero == $past(run_zero & ph0))
        else $error("independent pin 0 wrong");

    stop_low_a: assert property (@(posedge core_clk) disable iff (rst)
        ce && !run_one && (mode == dprt_pkg::DPRT_MODE_INDEP) |=> !pulse_channel_one)
        else $error("stopped channel drives high");

    casc_tick_a: assert property (@(posedge core_clk) disable iff (rst)
        (mode == dprt_pkg::DPRT_MODE_W16) && !uf0 |-> !uf1)
        else $error("upper half moved without lower underflow");

    w16_flip1_a: assert property (@(posedge core_clk) disable iff (rst)
        upper_step_s |=> pulse_channel_one != $past(pulse_channel_one))
        else $error("16-bit pin 1 did not invert on upper underflow");

    p8_pin1_a: assert property (@(posedge core_clk) disable iff (rst)
        m_p8p8 && ce |=> pulse_channel_one == $past(run1 & ph1))
        else $error("prescaled pin 1 wrong");

    casc_hold_a: assert property (@(posedge core_clk) disable iff (rst)
        no_lower_step_s |=> $stable(ph1))
        else $error("cascaded channel 1 stepped without a prescaler underflow");

    lower_phase_a: assert property (@(posedge core_clk) disable iff (rst)
        lower_uf_s |=> ph0 != $past(ph0))
        else $error("channel 0 phase did not alternate on underflow");

    upper_phase_a: assert property (@(posedge core_clk) disable iff (rst)
        ce && uf1 |=> ph1 != $past(ph1))
        else $error("channel 1 phase did not alternate on underflow");

    pins_frozen_a: assert property (@(posedge core_clk) disable iff (rst)
        !ce |=> $stable(pulse_channel_zero) && $stable(pulse_channel_one))
        else $error("pins moved while the clock enable was low");

    stop_zero_a: assert property (@(posedge core_clk) disable iff (rst)
        ce && !run_zero && m_indep |=> !pulse_channel_zero)
        else $error("stopped channel 0 drives high");

endmodule

// >>> tb/dprt_sink.sv
`timescale 1ns/10ps
// reports each finished level run on a pin and its length in cycles
module dprt_sink (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        pin,
    output logic             seen,
    output logic             lvl,
    output logic [15:0]      width
);
    logic        last_reg;
    logic [15:0] cnt_reg;

    always_ff @(posedge core_clk) begin
        seen     <= !rst && (pin !== last_reg);
        lvl      <= last_reg;
        width    <= cnt_reg;
        last_reg <= pin;
        cnt_reg  <= (rst || pin !== last_reg) ? 16'h1 : cnt_reg + 16'h1;
    end
endmodule

// >>> tb/dprt_top_tb.sv
`timescale 1ns/10ps
module dprt_top_tb;
    logic        core_clk   = 1'b0;
    logic        rst        = 1'b1;
    logic        ce         = 1'b1;
    logic        run_zero   = 1'b0;
    logic        run_one    = 1'b0;
    logic [1:0]  mode       = 2'h0;
    logic [7:0]  rl [4]     = '{default: 8'h00};
    logic [1:0]  p;
    logic [1:0]  seen;
    logic [1:0]  lvl;
    logic [31:0] wd;
    logic [31:0] seed       = 32'h90aa66cf;
    logic [31:0] q [2][$];
    logic [15:0] a, b, c, d, ew;
    int          skip [2]   = '{0, 0};
    int          fail_count = 0;
    int          n_checks   = 0;

    always #10 core_clk = ~core_clk;

    dprt_top dprt_top_i (.core_clk(core_clk), .rst(rst), .ce(ce), .run_zero(run_zero),
        .run_one(run_one), .mode(mode), .zero_rld_low(rl[0]), .zero_rld_high(rl[1]),
        .one_rld_low(rl[2]), .one_rld_high(rl[3]), .pulse_channel_zero(p[0]),
        .pulse_channel_one(p[1]));
    dprt_sink dprt_sink_i [1:0] (.core_clk(core_clk), .rst(rst), .pin(p), .seen(seen),
        .lvl(lvl), .width(wd));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // stop, load, restart; notes hold {high run, low run} per period
    task automatic go(input logic [1:0] m, input logic [31:0] v, input logic [31:0] e0,
                      input logic [31:0] e1, input int n);
        run_zero <= 1'b0;
        run_one  <= 1'b0;
        repeat (4) @(posedge core_clk);
        mode <= m;
        rl   <= '{v[7:0], v[15:8], v[23:16], v[31:24]};
        @(posedge core_clk);
        skip = '{2, 2};
        repeat (n) begin
            q[0].push_back(e0);
            q[1].push_back(e1);
        end
        run_zero <= 1'b1;
        run_one  <= 1'b1;
        for (int t = 0; t < 3000 && (n == 0 || q[0].size() + q[1].size() > 0); t++)
            @(posedge core_clk);
        chk("notes left", 16'(q[0].size() + q[1].size()), 16'h0);
    endtask

    always @(negedge core_clk) begin
        for (int i = 0; i < 2; i++) begin
            if (seen[i] && skip[i] > 0) begin
                skip[i]--;
            end else if (seen[i] && q[i].size() > 0) begin
                ew = lvl[i] ? q[i][0][31:16] : q[i][0][15:0];
                chk("run width", wd[16*i+:16], ew);
                if (lvl[i])
                    void'(q[i].pop_front());
            end
        end
        if (mode == dprt_pkg::DPRT_MODE_W16 && run_one)
            chk("pin match", 16'(p[0]), 16'(p[1]));
    end

    initial begin
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            repeat (32) seed = lfsr(seed);
            {d, c, b, a} = {8'h0, seed[31:24], 8'h0, seed[23:16], 8'h0, seed[15:8], 8'h0,
                            seed[7:0]};
            go(dprt_pkg::DPRT_MODE_INDEP, seed, {b + 16'h1, a + 16'h1},
               {d + 16'h1, c + 16'h1}, 3);
            a = {12'h0, seed[3:0]} + 16'h1;
            c = {12'h0, seed[11:8]} + 16'h1;
            d = {12'h0, seed[19:16]} + 16'h1;
            go(dprt_pkg::DPRT_MODE_P8P8, {4'h0, seed[19:16], 4'h0, seed[11:8], 4'h0,
               seed[3:0], 4'h0, seed[3:0]}, {a, a}, {d * a, c * a}, 3);
        end
        // lower half underflows every 4 cycles; upper phases last 2 and 3 of those underflows
        go(dprt_pkg::DPRT_MODE_W16, 32'h02010003, 32'h000c0008, 32'h000c0008, 3);
        ce <= 1'b0;
        @(negedge core_clk) b = 16'(p);
        repeat (8) @(negedge core_clk);
        chk("frozen pins", 16'(p), b);
        @(posedge core_clk) ce <= 1'b1;
        summarize();
    end

    initial begin
        repeat (60000) @(posedge core_clk);
        fail_count++;
        summarize();
    end
endmodule
